// ===== common/ctre_pkg.sv
// Package for the capacitive touch result register bank.
// Assumes a 32-bit register port with word-aligned byte offsets.
package ctre_pkg;

	// Register byte offsets
	localparam logic [11:0] OFS_MODE_SELECT   = 12'h108;
	localparam logic [11:0] OFS_POINT2_XY     = 12'h11C;
	localparam logic [11:0] OFS_POINT5_Y      = 12'h120;
	localparam logic [11:0] OFS_POINT1_XY     = 12'h124;
	localparam logic [11:0] OFS_TAG_LOOKUP_XY = 12'h128;
	localparam logic [11:0] OFS_TAG_FIRST     = 12'h12C;
	localparam logic [11:0] OFS_TAG_LOOKUP2   = 12'h130;
	localparam logic [11:0] OFS_TAG_SECOND    = 12'h134;
	localparam logic [11:0] OFS_POINT5_X      = 12'h16C;
	localparam logic [11:0] OFS_POINT3_XY     = 12'h18C;
	localparam logic [11:0] OFS_POINT4_XY     = 12'h190;

	// Reset values
	localparam logic [31:0] RST_POINT_XY  = 32'h80008000;
	localparam logic [15:0] RST_COORD     = 16'h8000;
	localparam logic [31:0] RST_RAW_XY    = 32'h0FFFFFFF;
	localparam logic [31:0] RST_LOOKUP_XY = 32'h00000000;
	localparam logic [7:0]  RST_TAG       = 8'h00;
	localparam logic        RST_MODE      = 1'b1;

	// Field positions
	localparam int MODE_BIT  = 0;
	localparam int X_MSB     = 31;
	localparam int X_LSB     = 16;
	localparam int Y_MSB     = 15;
	localparam int TAG_WIDTH = 8;

	// Detection mode encoding of the mode bit
	localparam logic MODE_MULTI  = 1'b0;
	localparam logic MODE_SINGLE = 1'b1;

	// Number of touch points the engine tracks
	localparam int NUM_POINTS = 5;

endpackage

// ===== logic/ctre_tag_latch.sv
// Per-point tag result latch: loads once at end of frame.
// Assumes frame_done is a one-cycle pulse on clk.
`timescale 1ns/1ns
module ctre_tag_latch
(
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       frame_done,
	input  wire logic       enable,
	input  wire logic       touched,
	input  wire logic [7:0] tag_in,
	input  wire logic [31:0] xy_in,
	output logic [7:0]      tag_out,
	output logic [31:0]     xy_out
);
	typedef struct packed
	{
		logic [7:0]  tag;
		logic [31:0] xy;
	} ctre_latch_t;

	ctre_latch_t st_ff;
	ctre_latch_t nxt_st;

	// Only frame end may change the tag, so a host sees one stable value per frame
	always_comb
	begin
		nxt_st = st_ff;
		if (frame_done)                                          // [RQ7]
		begin
			nxt_st.xy = xy_in;                                   // [RQ12]
			if (enable && touched)
				nxt_st.tag = tag_in;                             // [RQ7] [RQ8]
			else
				nxt_st.tag = ctre_pkg::RST_TAG;                  // [RQ8]
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			st_ff.tag <= ctre_pkg::RST_TAG;
			st_ff.xy  <= ctre_pkg::RST_LOOKUP_XY;
		end
		else
			st_ff <= nxt_st;
	end

	assign tag_out = st_ff.tag;
	assign xy_out  = st_ff.xy;
endmodule

// ===== logic/ctre_result_regs.sv
// Result register bank of the capacitive touch engine.
// Assumes the engine presents coordinates, tags and frame end on clk;
// software uses a single-cycle strobe port with read data one cycle later.
`timescale 1ns/1ns
// How it works
// (RQ1) Second point word at 0x11C: X high, Y low, reset 0x80008000.
// (RQ2) Third point word: X bits 31..16, Y bits 15..0, reset 0x80008000.
// (RQ3) Fourth point word at 0x190, same layout and reset.
// (RQ4) Fifth point split into X at 0x16C and Y at 0x120, reset 0x8000.
// (RQ5) Points two to five are updated only in multi-touch mode.
// (RQ6) Single-touch mode shows raw X/Y at 0x11C, reset 0x0FFFFFFF.
// (RQ7) Tags load the object tag once, after the frame's last line.
// (RQ8) Tags are 1..255 when touched, zero at reset or without touch.
// (RQ9) First tag works in both modes, looked up at its lookup coordinate.
// (RQ10) Second-point tag at 0x134, multi-touch only, upper bits zero.
// (RQ11) Mode bit 0 at 0x108: 0 multi, 1 single, resets to 1.
// (RQ12) Lookup coordinates used for each tag are readable back.
// (RQ13) Reserved tag bits read zero; reads never change stored values.
module ctre_result_regs
(
	input  wire logic        clk,
	input  wire logic        reset,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	// Engine side: coordinate samples
	input  wire logic        sample_valid,
	input  wire logic [4:0]  point_touched,
	input  wire logic [31:0] point1_xy_in,
	input  wire logic [31:0] point2_xy_in,
	input  wire logic [31:0] point3_xy_in,
	input  wire logic [31:0] point4_xy_in,
	input  wire logic [31:0] point5_xy_in,
	input  wire logic [31:0] raw_xy_in,
	// Engine side: tag lookup
	input  wire logic        frame_done,
	input  wire logic [7:0]  tag1_in,
	input  wire logic [7:0]  tag2_in,
	input  wire logic [31:0] lookup1_xy_in,
	input  wire logic [31:0] lookup2_xy_in,
	// Mode seen by the engine
	output logic             single_touch_mode
);
	typedef struct packed
	{
		logic        mode;
		logic [31:0] p1;
		logic [31:0] p2;
		logic [31:0] p3;
		logic [31:0] p4;
		logic [15:0] p5x;
		logic [15:0] p5y;
		logic [31:0] raw;
		logic [31:0] rdata;
	} ctre_state_t;

	ctre_state_t st_ff;
	ctre_state_t nxt_st;

	logic [7:0]  tag1;
	logic [7:0]  tag2;
	logic [31:0] look1;
	logic [31:0] look2;
	logic        multi;

	// Widen an 8-bit tag; reserved bits read zero
	function automatic logic [31:0] ctre_tag_word(input logic [7:0] t);
		ctre_tag_word = {24'h000000, t};                         // [RQ13]
	endfunction

	assign multi = (st_ff.mode == ctre_pkg::MODE_MULTI);

	// First tag is live in both modes
	ctre_tag_latch u_tag1
	(
		.clk        (clk),
		.reset      (reset),
		.frame_done (frame_done),
		.enable     (1'b1),                                      // [RQ9]
		.touched    (point_touched[0]),
		.tag_in     (tag1_in),
		.xy_in      (lookup1_xy_in),
		.tag_out    (tag1),
		.xy_out     (look1)
	);

	// Second tag only counts in multi-touch mode
	ctre_tag_latch u_tag2
	(
		.clk        (clk),
		.reset      (reset),
		.frame_done (frame_done),
		.enable     (multi),                                     // [RQ10]
		.touched    (point_touched[1]),
		.tag_in     (tag2_in),
		.xy_in      (lookup2_xy_in),
		.tag_out    (tag2),
		.xy_out     (look2)
	);

	// Next state: mode write, coordinate capture and read data
	always_comb
	begin
		nxt_st = st_ff;
		// Mode register is the only writable field
		if (reg_wr && reg_addr == ctre_pkg::OFS_MODE_SELECT)
			nxt_st.mode = reg_wdata[ctre_pkg::MODE_BIT];         // [RQ11]
		// Coordinates follow each engine sample
		if (sample_valid)
		begin
			nxt_st.p1 = point1_xy_in;
			if (multi)                                           // [RQ5]
			begin
				nxt_st.p2  = point2_xy_in;                       // [RQ1]
				nxt_st.p3  = point3_xy_in;                       // [RQ2]
				nxt_st.p4  = point4_xy_in;                       // [RQ3]
				nxt_st.p5x = point5_xy_in[ctre_pkg::X_MSB:ctre_pkg::X_LSB]; // [RQ4]
				nxt_st.p5y = point5_xy_in[ctre_pkg::Y_MSB:0];    // [RQ4]
			end
			else
				nxt_st.raw = raw_xy_in;                          // [RQ6]
		end
		// Read data is valid only in the cycle after the strobe; reads store nothing
		nxt_st.rdata = 32'h00000000;                             // [RQ13]
		if (reg_rd)
		begin
			if (reg_addr == ctre_pkg::OFS_MODE_SELECT)
				nxt_st.rdata = {31'h00000000, st_ff.mode};
			else if (reg_addr == ctre_pkg::OFS_POINT2_XY)
				nxt_st.rdata = multi ? st_ff.p2 : st_ff.raw;     // [RQ1] [RQ6]
			else if (reg_addr == ctre_pkg::OFS_POINT5_Y)
				nxt_st.rdata = {16'h0000, st_ff.p5y};            // [RQ4]
			else if (reg_addr == ctre_pkg::OFS_POINT1_XY)
				nxt_st.rdata = st_ff.p1;
			else if (reg_addr == ctre_pkg::OFS_TAG_LOOKUP_XY)
				nxt_st.rdata = look1;                            // [RQ12]
			else if (reg_addr == ctre_pkg::OFS_TAG_FIRST)
				nxt_st.rdata = ctre_tag_word(tag1);              // [RQ9]
			else if (reg_addr == ctre_pkg::OFS_TAG_LOOKUP2)
				nxt_st.rdata = look2;                            // [RQ12]
			else if (reg_addr == ctre_pkg::OFS_TAG_SECOND)
				nxt_st.rdata = ctre_tag_word(tag2);              // [RQ10]
			else if (reg_addr == ctre_pkg::OFS_POINT5_X)
				nxt_st.rdata = {16'h0000, st_ff.p5x};            // [RQ4]
			else if (reg_addr == ctre_pkg::OFS_POINT3_XY)
				nxt_st.rdata = st_ff.p3;                         // [RQ2]
			else if (reg_addr == ctre_pkg::OFS_POINT4_XY)
				nxt_st.rdata = st_ff.p4;                         // [RQ3]
			else
				nxt_st.rdata = 32'h00000000;                     // Unmapped reads zero
		end
	end

	// State register; the single-touch reset mode matches power-up behaviour
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			st_ff.mode  <= ctre_pkg::RST_MODE;                   // [RQ11]
			st_ff.p1    <= ctre_pkg::RST_POINT_XY;
			st_ff.p2    <= ctre_pkg::RST_POINT_XY;               // [RQ1]
			st_ff.p3    <= ctre_pkg::RST_POINT_XY;               // [RQ2]
			st_ff.p4    <= ctre_pkg::RST_POINT_XY;               // [RQ3]
			st_ff.p5x   <= ctre_pkg::RST_COORD;                  // [RQ4]
			st_ff.p5y   <= ctre_pkg::RST_COORD;                  // [RQ4]
			st_ff.raw   <= ctre_pkg::RST_RAW_XY;                 // [RQ6]
			st_ff.rdata <= 32'h00000000;
		end
		else
			st_ff <= nxt_st;
	end

	assign reg_rdata         = st_ff.rdata;
	assign single_touch_mode = st_ff.mode;
endmodule

// ===== testbench/ctre_result_regs_sva.sv
// Checker for the touch result registers, bound to ctre_result_regs.
// Sees only the top module's ports; one clock, async reset.
`timescale 1ns/1ns
module ctre_result_regs_sva
(
	input wire logic	clk,
	input wire logic	reset,
	input wire logic [11:0]	reg_addr,
	input wire logic [31:0]	reg_wdata,
	input wire logic	reg_wr,
	input wire logic	reg_rd,
	input wire logic [31:0]	reg_rdata,
	input wire logic [4:0]	point_touched,
	input wire logic	frame_done,
	input wire logic [7:0]	tag1_in,
	input wire logic [7:0]	tag2_in,
	input wire logic	single_touch_mode
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Frame end, then a plain read of one offset in the next cycle
	sequence s_ev_rd(ev, a);
		ev && !reg_wr ##1 reg_rd && reg_addr == a && !frame_done; endsequence
	property p_mode_wr;
		reg_wr && reg_addr == 12'h108 |=> single_touch_mode == $past(reg_wdata[0]); endproperty
	a_mode_wr: assert property (p_mode_wr) else $error("mode write");
	property p_mode_hold;
		!(reg_wr && reg_addr == 12'h108) |=> $stable(single_touch_mode); endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
	property p_mode_rd;
		reg_rd && reg_addr == 12'h108 |=> reg_rdata == {31'h0, $past(single_touch_mode)}; endproperty
	a_mode_rd: assert property (p_mode_rd) else $error("mode read");
	property p_tag_rsv;
		reg_rd && (reg_addr == 12'h12C || reg_addr == 12'h134) |=> reg_rdata[31:8] == 24'h0; endproperty
	a_tag_rsv: assert property (p_tag_rsv) else $error("tag upper bits");
	property p_tag1;
		s_ev_rd(frame_done && point_touched[0], 12'h12C) |=> reg_rdata == {24'h0, $past(tag1_in, 2)};
	endproperty
	a_tag1: assert property (p_tag1) else $error("first tag");
	property p_tag_none;
		s_ev_rd(frame_done && !point_touched[0], 12'h12C) |=> reg_rdata == 32'h0; endproperty
	a_tag_none: assert property (p_tag_none) else $error("untouched tag");
	property p_tag2;
		s_ev_rd(frame_done && point_touched[1] && !single_touch_mode, 12'h134)
			|=> reg_rdata == {24'h0, $past(tag2_in, 2)}; endproperty
	a_tag2: assert property (p_tag2) else $error("second tag");
	property p_tag2_single;
		s_ev_rd(frame_done && single_touch_mode, 12'h134) |=> reg_rdata == 32'h0; endproperty
	a_tag2_single: assert property (p_tag2_single) else $error("second tag single");
endmodule
bind ctre_result_regs ctre_result_regs_sva u_sva (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .point_touched, .frame_done, .tag1_in, .tag2_in, .single_touch_mode);

// ===== testbench/test_ctre_result_regs.sv
// Bench for the touch result registers: drives every port itself.
// Read answers are checked in order against a queue of notes.
`timescale 1ns/1ns
module test_ctre_result_regs;
	logic		clk = 1'b0, reset, reg_wr, reg_rd, sample_valid, frame_done, rd_d;
	logic [4:0]	tch;
	logic [7:0]	t1, t2;
	logic [11:0]	reg_addr;
	logic [15:0]	st = 16'h4FF2;
	logic [31:0]	reg_wdata, reg_rdata, p2, p3, p4, p5, raw, lk, q, r, e, exp_q[$];
	int		n_fail = 0, checks = 0;
	ctre_result_regs dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.sample_valid, .point_touched(tch), .point1_xy_in(q), .point2_xy_in(p2),
		.point3_xy_in(p3), .point4_xy_in(p4), .point5_xy_in(p5), .raw_xy_in(raw),
		.frame_done, .tag1_in(t1), .tag2_in(t2), .lookup1_xy_in(lk), .lookup2_xy_in(r),
		.single_touch_mode());
	function automatic logic [31:0] rnd();
		st = {st[14:0], st[15] ^ st[13] ^ st[12] ^ st[10]};
		return {st, ~st};
	endfunction
	initial forever #4 clk = ~clk;
	// Answers stand for one cycle only, so compare mid-cycle
	always @(posedge clk) rd_d <= reg_rd;
	always @(negedge clk)
		if (rd_d === 1'b1)
		begin
			e = exp_q.pop_front();
			checks++;
			if (reg_rdata !== e) $display("unexpected reg_rdata: expected %h, seen %h", e, reg_rdata);
			n_fail += int'(reg_rdata !== e);
		end
	// One strobe cycle; also drops engine pulses so they last one cycle
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		if (!w) exp_q.push_back(d);
		{reg_wr, reg_rd, sample_valid, frame_done, reg_addr, reg_wdata} <= {w, !w, 2'b0, a, d};
		@(posedge clk);
	endtask
	task ev(input logic s, input logic f, input logic [4:0] c);
		{reg_wr, reg_rd, sample_valid, frame_done, tch} <= {2'b0, s, f, c};
		r = rnd();
		{p2, p3, p4, p5} <= {rnd(), rnd(), rnd(), rnd()};
		{raw, lk, t1, t2} <= {rnd(), rnd(), r[15:0] | 16'h0101};
		@(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d, n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// Reset values, multi-touch traffic, then single-touch mode
	initial
	begin
		{reset, reg_wr, reg_rd, sample_valid, frame_done, tch, t1, t2} = {5'h10, 21'h0};
		{reg_addr, reg_wdata, p2, p3, p4, p5, raw, lk, q, r} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		acc(1'b0, 12'h11C, 32'h0FFFFFFF);
		acc(1'b0, 12'h108, 32'h1);
		acc(1'b1, 12'h108, 32'h0);
		acc(1'b0, 12'h190, 32'h80008000);
		acc(1'b0, 12'h120, 32'h8000);
		ev(1'b1, 1'b1, 5'h03);
		acc(1'b0, 12'h134, {24'h0, t2});
		acc(1'b0, 12'h11C, p2);
		acc(1'b0, 12'h18C, p3);
		acc(1'b0, 12'h16C, {16'h0, p5[31:16]});
		acc(1'b1, 12'h12C, 32'hFFFFFFFF);
		acc(1'b0, 12'h12C, {24'h0, t1});
		repeat (12)
		begin
			ev(1'b0, 1'b1, 5'(rnd()));
			acc(1'b0, 12'h12C, {24'h0, tch[0] ? t1 : 8'h0});
		end
		acc(1'b1, 12'h108, 32'h1);
		acc(1'b0, 12'h11C, 32'h0FFFFFFF);
		q = {24'h0, tch[0] ? t1 : 8'h0};
		ev(1'b1, 1'b0, 5'h03);
		acc(1'b0, 12'h11C, raw);
		acc(1'b0, 12'h12C, q);
		ev(1'b0, 1'b1, 5'h03);
		acc(1'b0, 12'h134, 32'h0);
		acc(1'b0, 12'h128, lk);
		ev(1'b0, 1'b0, 5'h00);
		wrap_up;
	end
endmodule
